// ==== mcms_pkg.sv ====
// shared constants and types for the media converter mode select block
package mcms_pkg;
    localparam int CLK_PERIOD_NS = 4;
    localparam int STRAP_DELAY_NS = 3000;
    localparam int STRAP_CYC = (STRAP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FLP_PERIOD_NS = 16000000;
    localparam int FLP_PERIOD_CYC = FLP_PERIOD_NS / CLK_PERIOD_NS;
    localparam int FLP_LOSS_NS = 50000000;
    localparam int FLP_LOSS_CYC = FLP_LOSS_NS / CLK_PERIOD_NS;

    localparam logic [4:0] MODE_REG_ADDR = 5'h1E;
    localparam int BIT_HALF_DUPLEX_ADVERT_OFF = 15;
    localparam int BIT_AUTONEG_DISABLE = 14;
    localparam int BIT_SOFT_RESET = 13;
    localparam int BIT_LINK_LOSS_WARNING = 12;
    localparam int BIT_RELAY_MODE_OFF = 11;
    localparam int BIT_FULL_DUPLEX_ADVERT_OFF = 10;
    localparam int BIT_FIXED_RATE = 9;
    localparam int BIT_LOW_RATE_SELECT = 8;
    localparam logic [15:0] MODE_REG_RESET = 16'h0000;
    localparam logic [15:0] MODE_RW_MASK = 16'hDF00;

    localparam logic [1:0] LVL_LOW = 2'h0;
    localparam logic [1:0] LVL_MID = 2'h1;
    localparam logic [1:0] LVL_HIGH = 2'h2;

    localparam int PIN_DUPLEX = 0;
    localparam int PIN_SPEED = 2;
    localparam int PIN_FO_SPEED100 = 4;
    localparam int PIN_FO_AN = 5;
    localparam int PIN_TP_AN = 6;
    localparam int PIN_FO_SIGNAL = 7;
    localparam int PIN_TP_SIGNAL = 8;
    localparam int PIN_POWER_DOWN_N = 9;
    localparam int PIN_COUNT = 10;
    // power-down pin idles high; a zero here would fake a release edge after reset
    localparam logic [PIN_COUNT-1:0] PIN_IDLE = 10'h200;

    localparam logic [1:0] MDIO_OP_WRITE = 2'h1;
    localparam logic [1:0] MDIO_OP_READ = 2'h2;
    localparam logic [5:0] MDIO_PREAMBLE_LEN = 6'h20;
    localparam logic [4:0] MDIO_TA_BIT = 5'h0E;
    localparam logic [4:0] MDIO_FIRST_DATA = 5'h0F;
    localparam logic [4:0] MDIO_LAST_BIT = 5'h1F;

    typedef enum logic [2:0] {
        MCMS_FORCED10 = 3'b000,
        MCMS_FORCED100 = 3'b001,
        MCMS_NT_HALF = 3'b010,
        MCMS_NT_FULL = 3'b011,
        MCMS_TRANSPARENT = 3'b100,
        MCMS_UNDEFINED = 3'b101
    } mcms_mode_t;

    typedef enum logic {
        MCMS_MDIO_IDLE = 1'b0,
        MCMS_MDIO_FRAME = 1'b1
    } mcms_mdio_state_t;
endpackage

// ==== mcms_reg_if.sv ====
// register access carrier between the management slave and the mode core
`timescale 1ns/1ps
interface mcms_reg_if;
    logic wrEn;
    logic [15:0] wrData;
    logic [15:0] rdData;
    modport slave (output wrEn, output wrData, input rdData);
    modport core (input wrEn, input wrData, output rdData);
endinterface

// ==== mcms_mdio_slave.sv ====
// serial management slave serving the mode configuration register
`timescale 1ns/1ps
module mcms_mdio_slave #(
    parameter logic [4:0] PHY_ADDR = 5'h00
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic mdc,
    input wire logic mdioIn,
    output logic mdioOut,
    output logic mdioOe,
    mcms_reg_if.slave regBus
);
    logic [2:0] cSync, dSync;
    logic mdcF, mdioF, mdcPrev, next_mdcF, next_mdioF;
    mcms_pkg::mcms_mdio_state_t st, next_st;
    logic [5:0] preCnt, next_preCnt;
    logic [4:0] bitIdx, next_bitIdx;
    logic [13:0] hdr, next_hdr;
    logic [15:0] dataSh, next_dataSh;
    logic next_mdioOut, next_mdioOe, next_wrEn;
    logic [15:0] wrData, next_wrData;
    logic hit, mdcRise;

    // third stage must agree with second before a level counts
    always_comb begin
        next_mdcF = (cSync[1] == cSync[2]) ? cSync[2] : mdcF;
        next_mdioF = (dSync[1] == dSync[2]) ? dSync[2] : mdioF;
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cSync <= 3'h0;
            dSync <= 3'h0;
            mdcF <= 1'b0;
            mdioF <= 1'b0;
            mdcPrev <= 1'b0;
        end else begin
            cSync <= {cSync[1:0], mdc};
            dSync <= {dSync[1:0], mdioIn};
            mdcF <= next_mdcF;
            mdioF <= next_mdioF;
            mdcPrev <= mdcF;
        end
    end

    assign mdcRise = mdcF && !mdcPrev;
    assign hit = (hdr[9:5] == PHY_ADDR) && (hdr[4:0] == mcms_pkg::MODE_REG_ADDR);
    assign regBus.wrData = wrData;

    // preamble suppression is not supported: every frame needs 32 ones
    always_comb begin
        next_st = st;
        next_preCnt = preCnt;
        next_bitIdx = bitIdx;
        next_hdr = hdr;
        next_dataSh = dataSh;
        next_mdioOut = mdioOut;
        next_mdioOe = mdioOe;
        next_wrEn = 1'b0;
        next_wrData = wrData;
        if (mdcRise) begin
            unique case (st)
                mcms_pkg::MCMS_MDIO_IDLE: begin
                    if (mdioF) begin
                        if (preCnt != mcms_pkg::MDIO_PREAMBLE_LEN) begin
                            next_preCnt = preCnt + 6'h01;
                        end
                    end else if (preCnt == mcms_pkg::MDIO_PREAMBLE_LEN) begin
                        next_st = mcms_pkg::MCMS_MDIO_FRAME;
                        next_bitIdx = 5'h01;
                        next_hdr = 14'h0000;
                    end else begin
                        next_preCnt = 6'h00;
                    end
                end
                mcms_pkg::MCMS_MDIO_FRAME: begin
                    next_bitIdx = bitIdx + 5'h01;
                    if (bitIdx < mcms_pkg::MDIO_TA_BIT) begin
                        next_hdr = {hdr[12:0], mdioF};
                    end
                    if (hdr[11:10] == mcms_pkg::MDIO_OP_READ && hit) begin
                        if (bitIdx == mcms_pkg::MDIO_TA_BIT) begin
                            next_mdioOe = 1'b1;
                            next_mdioOut = 1'b0;
                            next_dataSh = regBus.rdData;
                        end else if (bitIdx >= mcms_pkg::MDIO_FIRST_DATA
                                     && bitIdx != mcms_pkg::MDIO_LAST_BIT) begin
                            next_mdioOut = dataSh[15];
                            next_dataSh = {dataSh[14:0], 1'b0};
                        end
                    end else if (bitIdx > mcms_pkg::MDIO_FIRST_DATA) begin
                        next_dataSh = {dataSh[14:0], mdioF};
                    end
                    if (bitIdx == mcms_pkg::MDIO_LAST_BIT) begin
                        next_st = mcms_pkg::MCMS_MDIO_IDLE;
                        next_preCnt = 6'h00;
                        next_mdioOe = 1'b0;
                        next_mdioOut = 1'b0;
                        if (hdr[11:10] == mcms_pkg::MDIO_OP_WRITE && hit) begin
                            next_wrEn = 1'b1;
                            next_wrData = {dataSh[14:0], mdioF};
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            st <= mcms_pkg::MCMS_MDIO_IDLE;
            preCnt <= 6'h00;
            bitIdx <= 5'h00;
            hdr <= 14'h0000;
            dataSh <= 16'h0000;
            mdioOut <= 1'b0;
            mdioOe <= 1'b0;
            regBus.wrEn <= 1'b0;
            wrData <= 16'h0000;
        end else begin
            st <= next_st;
            preCnt <= next_preCnt;
            bitIdx <= next_bitIdx;
            hdr <= next_hdr;
            dataSh <= next_dataSh;
            mdioOut <= next_mdioOut;
            mdioOe <= next_mdioOe;
            regBus.wrEn <= next_wrEn;
            wrData <= next_wrData;
        end
    end
endmodule

// ==== mcms_mode_select.sv ====
// operating mode select and non-transparent negotiation control
// Function
// - mode comes from pins at power up, later from register 30 writes.
// - speed low or bits 1,1,1 give forced 10 with negotiation off.
// - speed high or bits 1,1,0 give forced 100 with negotiation off.
// - link loss warning may be enabled in forced modes.
// - speed mid or bits 0,0,0 enable both speeds, transparent or not.
// - duplex low or relay off, half on, full off: non-transparent half.
// - duplex high or relay off, both advert bits clear: non-transparent full/half.
// - non-transparent needs duplex set, copper negotiates, fiber not, both speeds.
// - copper transmitter stays off until both inputs see signal.
// - fiber transmitter stays on, carrying copper input.
// - copper bursts start own bursts with fiber speed and chosen duplex.
// - keep bursting while copper bursts keep arriving.
// - half mode advertises half duplex only; paths stay independent.
// - only speed and duplex are advertised.
// - link loss warning cannot be enabled in non-transparent modes.
// - pins latched a few microseconds after reset, power-down release, reset bit.
// - duplex and speed pins both floating give transparent mode.
// - management writes override pin-latched values.
`timescale 1ns/1ps
module mcms_mode_select #(
    parameter logic [4:0] PHY_ADDR = 5'h00,
    parameter int unsigned FLP_PERIOD_CYC = mcms_pkg::FLP_PERIOD_CYC,
    parameter int unsigned FLP_LOSS_CYC = mcms_pkg::FLP_LOSS_CYC
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic mdc,
    input wire logic mdioIn,
    input wire logic [1:0] speedPin,
    input wire logic [1:0] duplexPin,
    input wire logic power_down_n,
    input wire logic tpSignal,
    input wire logic foSignal,
    input wire logic tpAnCapable,
    input wire logic foAnCapable,
    input wire logic foSpeed100,
    input wire logic tpFlpSeen,
    output logic mdioOut,
    output logic mdioOe,
    output mcms_pkg::mcms_mode_t opMode,
    output logic ntActive,
    output logic tpTxEnable,
    output logic foTxEnable,
    output logic liwEnable,
    output logic advert100,
    output logic advert10,
    output logic full_duplex_advert_off,
    output logic half_duplex_advert_off,
    output logic flpBurst
);
    localparam int NP = mcms_pkg::PIN_COUNT;
    logic [NP-1:0] pinRaw, s1, s2, s3, pinF, next_pinF;
    logic [1:0] spdL, dupL;
    mcms_reg_if regBus ();
    assign pinRaw = {power_down_n, tpSignal, foSignal, tpAnCapable, foAnCapable,
                     foSpeed100, speedPin, duplexPin};
    for (genvar gi = 0; gi < NP; gi++) begin : g_sync
        always_ff @(posedge clock or negedge rst_b) begin
            if (!rst_b) begin
                s1[gi] <= mcms_pkg::PIN_IDLE[gi];
                s2[gi] <= mcms_pkg::PIN_IDLE[gi];
                s3[gi] <= mcms_pkg::PIN_IDLE[gi];
            end else begin
                s1[gi] <= pinRaw[gi];
                s2[gi] <= s1[gi];
                s3[gi] <= s2[gi];
            end
        end
        always_comb begin
            next_pinF[gi] = (s2[gi] == s3[gi]) ? s3[gi] : pinF[gi];
        end
    end
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pinF <= mcms_pkg::PIN_IDLE;
        end else begin
            pinF <= next_pinF;
        end
    end
    assign spdL = pinF[mcms_pkg::PIN_SPEED +: 2];
    assign dupL = pinF[mcms_pkg::PIN_DUPLEX +: 2];
    mcms_mdio_slave #(.PHY_ADDR(PHY_ADDR)) u_mdio (
        .clock(clock),
        .rst_b(rst_b),
        .mdc(mdc),
        .mdioIn(mdioIn),
        .mdioOut(mdioOut),
        .mdioOe(mdioOe),
        .regBus(regBus)
    );
    // strap latch sequencing
    logic latchPending, next_latchPending, pdPrev, latchNow, resetWrite, pdRise;
    logic [9:0] strapCnt, next_strapCnt;
    assign pdRise = pinF[mcms_pkg::PIN_POWER_DOWN_N] && !pdPrev;
    assign resetWrite = regBus.wrEn && regBus.wrData[mcms_pkg::BIT_SOFT_RESET];
    assign latchNow = latchPending && strapCnt == 10'(mcms_pkg::STRAP_CYC - 1);
    always_comb begin
        next_latchPending = latchPending;
        next_strapCnt = strapCnt;
        if (pdRise || resetWrite) begin
            next_latchPending = 1'b1;
            next_strapCnt = 10'h000;
        end else if (latchNow) begin
            next_latchPending = 1'b0;
        end else if (latchPending) begin
            next_strapCnt = strapCnt + 10'h001;
        end
    end
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            latchPending <= 1'b1;
            strapCnt <= 10'h000;
            pdPrev <= 1'b1;
        end else begin
            latchPending <= next_latchPending;
            strapCnt <= next_strapCnt;
            pdPrev <= pinF[mcms_pkg::PIN_POWER_DOWN_N];
        end
    end
    // mode register
    logic [15:0] modeReg, next_modeReg;
    always_comb begin
        next_modeReg = modeReg;
        if (latchNow) begin
            // both pins decoded as one pair
            next_modeReg[mcms_pkg::BIT_AUTONEG_DISABLE] = spdL != mcms_pkg::LVL_MID;
            next_modeReg[mcms_pkg::BIT_FIXED_RATE] = spdL != mcms_pkg::LVL_MID;
            next_modeReg[mcms_pkg::BIT_LOW_RATE_SELECT] = spdL == mcms_pkg::LVL_LOW;
            // duplex high means full and half
            next_modeReg[mcms_pkg::BIT_RELAY_MODE_OFF] = dupL != mcms_pkg::LVL_MID;
            next_modeReg[mcms_pkg::BIT_FULL_DUPLEX_ADVERT_OFF] = dupL == mcms_pkg::LVL_LOW;
            next_modeReg[mcms_pkg::BIT_HALF_DUPLEX_ADVERT_OFF] = 1'b0;
        end
        if (regBus.wrEn) begin
            next_modeReg = regBus.wrData & mcms_pkg::MODE_RW_MASK;
        end
    end
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            modeReg <= mcms_pkg::MODE_REG_RESET;
        end else begin
            modeReg <= next_modeReg;
        end
    end
    // reset bit reads back while the latch delay runs
    always_comb begin
        regBus.rdData = modeReg;
        regBus.rdData[mcms_pkg::BIT_SOFT_RESET] = latchPending;
    end
    // mode decode and path control, recomputed every cycle so a write reaches the outputs two clocks after wrEn
    mcms_pkg::mcms_mode_t next_opMode;
    logic next_ntActive, next_tpTx, next_liw, an, fx, lo, ro;
    assign an = modeReg[mcms_pkg::BIT_AUTONEG_DISABLE];
    assign fx = modeReg[mcms_pkg::BIT_FIXED_RATE];
    assign lo = modeReg[mcms_pkg::BIT_LOW_RATE_SELECT];
    assign ro = modeReg[mcms_pkg::BIT_RELAY_MODE_OFF];
    always_comb begin
        if (an && fx) begin
            next_opMode = lo ? mcms_pkg::MCMS_FORCED10 : mcms_pkg::MCMS_FORCED100;
        end else if (!an && !fx && !lo && !modeReg[mcms_pkg::BIT_HALF_DUPLEX_ADVERT_OFF]) begin
            if (!ro) begin
                next_opMode = modeReg[mcms_pkg::BIT_FULL_DUPLEX_ADVERT_OFF]
                              ? mcms_pkg::MCMS_UNDEFINED : mcms_pkg::MCMS_TRANSPARENT;
            end else if (modeReg[mcms_pkg::BIT_FULL_DUPLEX_ADVERT_OFF]) begin
                next_opMode = mcms_pkg::MCMS_NT_HALF;
            end else begin
                next_opMode = mcms_pkg::MCMS_NT_FULL;
            end
        end else begin
            next_opMode = mcms_pkg::MCMS_UNDEFINED;
        end
        next_ntActive = (next_opMode == mcms_pkg::MCMS_NT_HALF
                         || next_opMode == mcms_pkg::MCMS_NT_FULL)
                        && pinF[mcms_pkg::PIN_TP_AN] && !pinF[mcms_pkg::PIN_FO_AN];
        next_tpTx = !next_ntActive
                    || (pinF[mcms_pkg::PIN_TP_SIGNAL] && pinF[mcms_pkg::PIN_FO_SIGNAL]);
        next_liw = modeReg[mcms_pkg::BIT_LINK_LOSS_WARNING]
                   && (next_opMode == mcms_pkg::MCMS_FORCED10
                       || next_opMode == mcms_pkg::MCMS_FORCED100);
    end
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            opMode <= mcms_pkg::MCMS_TRANSPARENT;
            ntActive <= 1'b0;
            tpTxEnable <= 1'b0;
            foTxEnable <= 1'b0;
            liwEnable <= 1'b0;
            advert100 <= 1'b0;
            advert10 <= 1'b0;
            full_duplex_advert_off <= 1'b0;
            half_duplex_advert_off <= 1'b0;
        end else begin
            opMode <= next_opMode;
            ntActive <= next_ntActive;
            tpTxEnable <= next_tpTx;
            foTxEnable <= 1'b1;
            liwEnable <= next_liw;
            advert100 <= pinF[mcms_pkg::PIN_FO_SPEED100];
            advert10 <= !pinF[mcms_pkg::PIN_FO_SPEED100];
            full_duplex_advert_off <= !modeReg[mcms_pkg::BIT_FULL_DUPLEX_ADVERT_OFF];
            half_duplex_advert_off <= !modeReg[mcms_pkg::BIT_HALF_DUPLEX_ADVERT_OFF];
        end
    end
    // own burst generation; the partner decides when the link is settled
    logic flpActive, next_flpActive, next_flpBurst;
    logic [23:0] flpTimer, next_flpTimer, lossTimer, next_lossTimer;
    always_comb begin
        next_flpActive = flpActive;
        next_flpTimer = flpTimer;
        next_lossTimer = lossTimer;
        next_flpBurst = 1'b0;
        if (!ntActive) begin
            next_flpActive = 1'b0;
            next_flpTimer = 24'h000000;
            next_lossTimer = 24'h000000;
        end else if (tpFlpSeen && !flpActive) begin
            next_flpActive = 1'b1;
            next_flpBurst = 1'b1;
            next_flpTimer = 24'h000000;
            next_lossTimer = 24'h000000;
        end else if (flpActive) begin
            next_lossTimer = tpFlpSeen ? 24'h000000 : lossTimer + 24'h000001;
            if (!tpFlpSeen && lossTimer == 24'(FLP_LOSS_CYC - 1)) begin
                next_flpActive = 1'b0;
            end else if (flpTimer == 24'(FLP_PERIOD_CYC - 1)) begin
                next_flpBurst = 1'b1;
                next_flpTimer = 24'h000000;
            end else begin
                next_flpTimer = flpTimer + 24'h000001;
            end
        end
    end
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            flpActive <= 1'b0;
            flpTimer <= 24'h000000;
            lossTimer <= 24'h000000;
            flpBurst <= 1'b0;
        end else begin
            flpActive <= next_flpActive;
            flpTimer <= next_flpTimer;
            lossTimer <= next_lossTimer;
            flpBurst <= next_flpBurst;
        end
    end
    forced_ten_a: assert property (@(posedge clock) disable iff (!rst_b)
        (an && fx && lo) |=> opMode == mcms_pkg::MCMS_FORCED10)
        else $error("forced 10 bits did not select forced 10");
    tp_gate_a: assert property (@(posedge clock) disable iff (!rst_b)
        (ntActive && tpTxEnable) |-> $past(pinF[mcms_pkg::PIN_TP_SIGNAL], 1)
                                     && $past(pinF[mcms_pkg::PIN_FO_SIGNAL], 1))
        else $error("copper transmitter enabled without both signals");
    fo_on_a: assert property (@(posedge clock) disable iff (!rst_b)
        ntActive |-> foTxEnable)
        else $error("fiber transmitter off in non-transparent mode");
    liw_block_a: assert property (@(posedge clock) disable iff (!rst_b)
        liwEnable |-> !ntActive && (opMode == mcms_pkg::MCMS_FORCED10
                                    || opMode == mcms_pkg::MCMS_FORCED100))
        else $error("link loss warning enabled outside forced modes");
    half_only_a: assert property (@(posedge clock) disable iff (!rst_b)
        (opMode == mcms_pkg::MCMS_NT_HALF) |-> !full_duplex_advert_off && half_duplex_advert_off)
        else $error("half mode advertised full duplex");
    burst_cause_a: assert property (@(posedge clock) disable iff (!rst_b)
        flpBurst |-> $past(ntActive, 1) && ($past(flpActive, 1) || $past(tpFlpSeen, 1)))
        else $error("burst sent without partner bursts");
    write_wins_a: assert property (@(posedge clock) disable iff (!rst_b)
        regBus.wrEn |=> modeReg == ($past(regBus.wrData) & mcms_pkg::MODE_RW_MASK))
        else $error("management write did not take precedence");
    strap_mid_a: assert property (@(posedge clock) disable iff (!rst_b)
        (latchNow && !regBus.wrEn && dupL == mcms_pkg::LVL_MID
         && spdL == mcms_pkg::LVL_MID) |=> ##1 opMode == mcms_pkg::MCMS_TRANSPARENT)
        else $error("floating pins did not give transparent mode");
endmodule

// ==== mcms_link_partner.sv ====
// copper and fiber link partner stand-in for the mode select bench
`timescale 1ns/1ps
module mcms_link_partner #(
    parameter int FO_DELAY = 30
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic linkUp,
    input wire logic burstReq,
    output logic tpSignal,
    output logic foSignal,
    output logic tpFlpSeen
);
    int foCnt;
    // fiber side is slow, so copper signal shows first
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            foCnt <= 0;
            tpSignal <= 1'b0;
            foSignal <= 1'b0;
            tpFlpSeen <= 1'b0;
        end else begin
            foCnt <= linkUp ? foCnt + 1 : 0;
            tpSignal <= linkUp;
            foSignal <= linkUp && foCnt >= FO_DELAY;
            tpFlpSeen <= burstReq;
        end
    end
endmodule

// ==== mcms_testbench.sv ====
// self-checking bench for the mode select block
`timescale 1ns/1ps
module testbench;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic mdc = 1'b0;
    logic mOe = 1'b0;
    logic mBit = 1'b1;
    logic [1:0] speedPin = mcms_pkg::LVL_LOW;
    logic [1:0] duplexPin = mcms_pkg::LVL_MID;
    logic power_down_n = 1'b1;
    logic linkUp = 1'b0;
    logic burstReq = 1'b0;
    logic tpAnCapable = 1'b1;
    logic foAnCapable = 1'b0;
    logic foSpeed100 = 1'b1;
    int err_count = 0;
    int n_checks = 0;
    logic mdioOut, mdioOe, tpSignal, foSignal, tpFlpSeen, flpBurst, ntActive;
    logic tpTxEnable, foTxEnable, liwEnable, advert100, advert10, full_duplex_advert_off, half_duplex_advert_off;
    mcms_pkg::mcms_mode_t opMode;
    // released line floats high through the pull-up
    wire logic line = mdioOe ? mdioOut : (mOe ? mBit : 1'b1);
    wire logic [15:0] sts = {5'h00, opMode, ntActive, tpTxEnable, foTxEnable, liwEnable,
        advert100, advert10, full_duplex_advert_off, half_duplex_advert_off};
    always #2 clock = ~clock;
    mcms_link_partner peer (.clock, .rst_b, .linkUp, .burstReq, .tpSignal, .foSignal,
        .tpFlpSeen);
    mcms_mode_select #(.FLP_PERIOD_CYC(20), .FLP_LOSS_CYC(50)) dut (.clock, .rst_b, .mdc,
        .mdioIn(line), .speedPin, .duplexPin, .power_down_n, .tpSignal, .foSignal,
        .tpAnCapable, .foAnCapable, .foSpeed100, .tpFlpSeen, .mdioOut, .mdioOe, .opMode,
        .ntActive, .tpTxEnable, .foTxEnable, .liwEnable, .advert100, .advert10, .full_duplex_advert_off,
        .half_duplex_advert_off, .flpBurst);
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        if (err_count == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // eight clocks per mdc half period, data set while mdc is low
    task automatic mdio(input logic [1:0] op, input logic [15:0] wd, output logic [15:0] rd);
        logic [63:0] f;
        f = {32'hFFFFFFFF, 2'h1, op, 5'h00, mcms_pkg::MODE_REG_ADDR, 2'h2, wd};
        for (int i = 63; i >= 0; i--) begin
            mOe = op == mcms_pkg::MDIO_OP_WRITE || i > 17;
            mBit = f[i];
            tick(8);
            rd = {rd[14:0], line};
            mdc = 1'b1;
            tick(8);
            mdc = 1'b0;
        end
        mOe = 1'b0;
        tick(12);
    endtask
    task automatic t_forced100();
        logic [15:0] rd;
        mdio(mcms_pkg::MDIO_OP_WRITE, 16'h52FF, rd);
        chk(sts & 16'h07F0, 16'h0170);
        mdio(mcms_pkg::MDIO_OP_READ, 16'h0000, rd);
        chk(rd, 16'h5200);
    endtask
    task automatic t_nt_full();
        logic [15:0] rd;
        mdio(mcms_pkg::MDIO_OP_WRITE, 16'h0800, rd);
        chk(sts, 16'h03AB);
        linkUp = 1'b1;
        tick(15);
        chk(sts & 16'h0040, 16'h0000);
        tick(40);
        chk(sts, 16'h03EB);
    endtask
    // one copper burst: bursts every period until the loss time runs out
    task automatic t_burst(input logic [15:0] exp);
        int n;
        n = 0;
        burstReq = 1'b1;
        tick(1);
        burstReq = 1'b0;
        for (int c = 0; c < 100; c++) begin
            tick(1);
            n += flpBurst;
        end
        chk(16'(n), exp);
    endtask
    task automatic t_nt_half();
        logic [15:0] rd;
        foSpeed100 = 1'b0;
        mdio(mcms_pkg::MDIO_OP_WRITE, 16'h1C00, rd);
        chk(sts, 16'h02E5);
        foAnCapable = 1'b1;
        tick(10);
        chk(sts & 16'h0780, 16'h0200);
        foAnCapable = 1'b0;
        tpAnCapable = 1'b0;
        tick(10);
        chk(sts & 16'h0780, 16'h0200);
        t_burst(16'h0000);
        mdio(mcms_pkg::MDIO_OP_WRITE, 16'h0000, rd);
        chk(sts & 16'h0710, 16'h0400);
        // half advert off set matches no mode row
        mdio(mcms_pkg::MDIO_OP_WRITE, 16'h8800, rd);
        chk(sts & 16'h0780, 16'h0500);
    endtask
    task automatic t_pd_strap();
        logic [15:0] rd;
        logic [1:0] lv[3] = '{mcms_pkg::LVL_LOW, mcms_pkg::LVL_HIGH, mcms_pkg::LVL_MID};
        mcms_pkg::mcms_mode_t md[3] = '{mcms_pkg::MCMS_NT_HALF, mcms_pkg::MCMS_NT_FULL,
            mcms_pkg::MCMS_TRANSPARENT};
        for (int k = 0; k < 3; k++) begin
            speedPin = mcms_pkg::LVL_MID;
            duplexPin = lv[k];
            power_down_n = 1'b0;
            tick(10);
            power_down_n = 1'b1;
            tick(800);
            chk(sts & 16'h0700, {5'h00, md[k], 8'h00});
        end
        // pins are not live: the reset bit re-latches them after the latch delay
        duplexPin = mcms_pkg::LVL_HIGH;
        mdio(mcms_pkg::MDIO_OP_WRITE, 16'h2000, rd);
        chk(sts & 16'h0700, 16'h0400);
        tick(800);
        chk(sts & 16'h0700, 16'h0300);
    endtask
    initial begin
        tick(3);
        rst_b = 1'b1;
        tick(800);
        chk(sts & 16'h07F0, 16'h0060);
        t_forced100();
        t_nt_full();
        t_burst(16'h0003);
        t_nt_half();
        t_pd_strap();
        final_report();
    end
    // hang guard
    initial begin
        #400000;
        err_count++;
        final_report();
    end
endmodule
